// ===== core/rtb_timer.sv
/*
  Reload timer with baud select: 16-bit auto-reload up counter, overflow flag,
  prescaler, serial-port steering bits and an Avalon-MM register slave.
  Assumes one clock, a synchronous reset, same-clock cpu and uart inputs.
*/
`timescale 1ns/10ps
module rtb_timer
(
  input wire logic mclk, // system clock, 50 MHz
  input wire logic srst, // synchronous reset, active high
  input wire logic [rtb_pkg::RTB_ADDR_W-1:0] avs_address, // byte address
  input wire logic avs_read, // read strobe
  input wire logic avs_write, // write strobe
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // byte lanes
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall
  input wire logic isr_enter, // pulse: cpu vectors to timer service
  input wire logic [1:0] uart0_mode, // uart0 mode
  input wire logic [1:0] uart1_mode, // uart1 mode
  input wire logic uart1_framing_error, // uart1 framing error flag
  input wire logic uart1_mode_bit0, // uart1 mode bit
  output logic overflow_tick, // pulse per overflow, baud clock
  output logic uart0_use_this_timer, // uart0 baud from this timer
  output logic uart1_double_rate, // uart1 baud doubled
  output logic uart1_control_bit7, // value seen at uart1 control bit 7
  output logic irq // level interrupt
);
  import rtb_pkg::*;

  typedef struct packed {
    rtb_bus_e bus;
    logic [31:0] rdata;
    logic [7:0] ctrl;
    logic [7:0] rlo;
    logic [7:0] rhi;
    logic [15:0] cnt;
    logic [RTB_IRQ_N-1:0] stat;
    logic [RTB_IRQ_N-1:0] ien;
    logic ovf_tick;
    logic u0_sel;
    logic u1_dbl;
    logic u1_b7;
    logic irq;
  } rtb_top_s;

  rtb_top_s st_q;
  rtb_top_s st_d;
  logic tick;
  logic wr_hit;
  logic [7:0] idx;
  logic [7:0] wbyte;
  logic wrap;
  logic sw_ovf_wr;
  logic [7:0] ctrl_v;
  logic [RTB_IRQ_N-1:0] ev;

  rtb_prescaler u_pre
  (
    .mclk(mclk),
    .srst(srst),
    .run(st_q.ctrl[RTB_CTRL_RUN]),
    .sel(st_q.ctrl[RTB_CTRL_PS_HI:0]),
    .tick(tick)
  );

  always_comb
  begin
    st_d = st_q;
    idx = avs_address[RTB_IDX_LSB +: 8];
    wbyte = avs_writedata[7:0];
    wr_hit = (st_q.bus == RTB_IDLE) && avs_write && avs_byteenable[0];
    sw_ovf_wr = wr_hit && (idx == RTB_IDX_CTRL);
    st_d.ovf_tick = 1'b0;
    wrap = 1'b0;
    ev = '0;

    // counting and reload
    if (tick && st_q.ctrl[RTB_CTRL_RUN])
    begin
      if (st_q.cnt == RTB_CNT_MAX)
      begin
        wrap = 1'b1;
        st_d.cnt = {st_q.rhi, st_q.rlo};
        st_d.ovf_tick = 1'b1;
      end
      else
      begin
        st_d.cnt = 16'(st_q.cnt + 16'h0001);
      end
    end

    // control register; hardware set beats any clear
    ctrl_v = st_q.ctrl;
    if (sw_ovf_wr)
    begin
      ctrl_v = wbyte;
    end
    else if (isr_enter)
    begin
      ctrl_v[RTB_CTRL_OVF] = 1'b0;
    end
    if (wrap)
    begin
      ctrl_v[RTB_CTRL_OVF] = 1'b1;
    end
    st_d.ctrl = ctrl_v;

    // reload bytes; writing them while running is the software's hazard
    if (wr_hit && idx == RTB_IDX_RLO)
    begin
      st_d.rlo = wbyte;
    end
    if (wr_hit && idx == RTB_IDX_RHI)
    begin
      st_d.rhi = wbyte;
    end

    // sticky interrupt status, set wins over clear
    ev[RTB_IRQ_OVF] = wrap;
    ev[RTB_IRQ_ACK] = isr_enter;
    if (wr_hit && idx == RTB_IDX_IRQ_EN)
    begin
      st_d.ien = wbyte[RTB_IRQ_N-1:0];
    end
    if (wr_hit && idx == RTB_IDX_IRQ_CLR)
    begin
      st_d.stat = (st_q.stat & ~wbyte[RTB_IRQ_N-1:0]) | ev;
    end
    else
    begin
      st_d.stat = st_q.stat | ev;
    end
    st_d.irq = |(st_d.stat & st_d.ien);

    // serial port steering
    st_d.u0_sel = st_d.ctrl[RTB_CTRL_BRSRC]
      && (uart0_mode == RTB_UMODE1 || uart0_mode == RTB_UMODE3);
    st_d.u1_dbl = st_d.ctrl[RTB_CTRL_DBL] && (uart1_mode == RTB_UMODE2);
    st_d.u1_b7 = st_d.ctrl[RTB_CTRL_FESEL] ? uart1_framing_error
      : uart1_mode_bit0;

    // bus: every access answered one cycle after it is seen
    unique case (st_q.bus)
      RTB_IDLE:
      begin
        if (avs_read || avs_write)
        begin
          st_d.bus = RTB_RESP;
          st_d.rdata = 32'h0000_0000;
          if (avs_read)
          begin
            unique case (idx)
              RTB_IDX_CTRL: st_d.rdata[7:0] = st_q.ctrl;
              RTB_IDX_RLO: st_d.rdata[7:0] = st_q.rlo;
              RTB_IDX_RHI: st_d.rdata[7:0] = st_q.rhi;
              RTB_IDX_CNT_LO: st_d.rdata[7:0] = st_q.cnt[7:0];
              RTB_IDX_CNT_HI: st_d.rdata[7:0] = st_q.cnt[15:8];
              RTB_IDX_IRQ_STAT: st_d.rdata[RTB_IRQ_N-1:0] = st_q.stat;
              RTB_IDX_IRQ_EN: st_d.rdata[RTB_IRQ_N-1:0] = st_q.ien;
              RTB_IDX_UART:
              begin
                st_d.rdata[RTB_UART_U0M_LO +: 2] = uart0_mode;
                st_d.rdata[RTB_UART_U1M_LO +: 2] = uart1_mode;
              end
              default: st_d.rdata = 32'h0000_0000;
            endcase
          end
        end
      end
      RTB_RESP:
      begin
        st_d.bus = RTB_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      st_q.bus <= RTB_IDLE;
      st_q.rdata <= 32'h0000_0000;
      st_q.ctrl <= RTB_CTRL_RST;
      st_q.rlo <= RTB_RELOAD_RST;
      st_q.rhi <= RTB_RELOAD_RST;
      st_q.cnt <= RTB_CNT_RST;
      st_q.stat <= '0;
      st_q.ien <= '0;
      st_q.ovf_tick <= 1'b0;
      st_q.u0_sel <= 1'b0;
      st_q.u1_dbl <= 1'b0;
      st_q.u1_b7 <= 1'b0;
      st_q.irq <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // waitrequest high except in the answer cycle
  assign avs_waitrequest = (st_q.bus != RTB_RESP);
  assign avs_readdata = st_q.rdata;
  assign overflow_tick = st_q.ovf_tick;
  assign uart0_use_this_timer = st_q.u0_sel;
  assign uart1_double_rate = st_q.u1_dbl;
  assign uart1_control_bit7 = st_q.u1_b7;
  assign irq = st_q.irq;
endmodule : rtb_timer

// ===== core/rtb_pkg.sv
/*
  Package for the reload timer with baud select: register map, field layout,
  reset values, interrupt bits and bus state encoding.
  Assumes a 32-bit Avalon-MM slave with byte addresses, one word per register.
*/
package rtb_pkg;
  // printed offsets are not multiples of four: they are indices
  localparam logic [7:0] RTB_IDX_CTRL = 8'hC4;
  localparam logic [7:0] RTB_IDX_RLO = 8'hC5;
  localparam logic [7:0] RTB_IDX_RHI = 8'hC6;
  localparam logic [7:0] RTB_IDX_CNT_LO = 8'hD0;
  localparam logic [7:0] RTB_IDX_CNT_HI = 8'hD1;
  localparam logic [7:0] RTB_IDX_IRQ_STAT = 8'hD2;
  localparam logic [7:0] RTB_IDX_IRQ_EN = 8'hD3;
  localparam logic [7:0] RTB_IDX_IRQ_CLR = 8'hD4;
  localparam logic [7:0] RTB_IDX_UART = 8'hD5;
  localparam int RTB_ADDR_W = 10;
  localparam int RTB_IDX_LSB = 2;

  localparam int RTB_CTRL_DBL = 7;
  localparam int RTB_CTRL_FESEL = 6;
  localparam int RTB_CTRL_BRSRC = 5;
  localparam int RTB_CTRL_OVF = 4;
  localparam int RTB_CTRL_RUN = 3;
  localparam int RTB_CTRL_PS_HI = 2;

  // uart status register layout: [1:0] uart0 mode, [3:2] uart1 mode
  localparam int RTB_UART_U0M_LO = 0;
  localparam int RTB_UART_U1M_LO = 2;

  localparam logic [7:0] RTB_CTRL_RST = 8'h00;
  localparam logic [7:0] RTB_RELOAD_RST = 8'h00;
  localparam logic [15:0] RTB_CNT_RST = 16'h0000;
  localparam logic [15:0] RTB_CNT_MAX = 16'hFFFF;
  localparam logic [6:0] RTB_PRE_RST = 7'h00;

  localparam int RTB_IRQ_N = 2;
  localparam int RTB_IRQ_OVF = 0;
  localparam int RTB_IRQ_ACK = 1;

  localparam logic [1:0] RTB_UMODE1 = 2'h1;
  localparam logic [1:0] RTB_UMODE2 = 2'h2;
  localparam logic [1:0] RTB_UMODE3 = 2'h3;

  typedef enum logic [1:0] {
    RTB_IDLE = 2'b01,
    RTB_RESP = 2'b10
  } rtb_bus_e;
endpackage : rtb_pkg

// ===== core/rtb_prescaler.sv
/*
  Power-of-two prescaler producing a one-cycle count enable.
  Assumes run is a same-clock level; the divider is held cleared while halted.
*/
`timescale 1ns/10ps
module rtb_prescaler
(
  input wire logic mclk, // system clock
  input wire logic srst, // synchronous reset
  input wire logic run, // count while high
  input wire logic [2:0] sel, // divide code
  output logic tick // one-cycle enable
);
  import rtb_pkg::*;

  typedef struct packed {
    logic [6:0] div;
    logic tick;
  } rtb_pre_s;

  rtb_pre_s st_q;
  rtb_pre_s st_d;
  logic [6:0] mask;

  always_comb
  begin
    mask = 7'(({7'h00, 1'b1} << sel) - 8'h01);
    st_d = st_q;
    st_d.tick = 1'b0;
    if (!run)
    begin
      st_d.div = RTB_PRE_RST;
    end
    else if ((st_q.div & mask) == mask)
    begin
      st_d.div = RTB_PRE_RST;
      st_d.tick = 1'b1;
    end
    else
    begin
      st_d.div = 7'(st_q.div + 7'h01);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      st_q <= '{div: RTB_PRE_RST, tick: 1'b0};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign tick = st_q.tick;
endmodule : rtb_prescaler

// ===== verification/rtb_timer_sva.sv
/* Checker for rtb_timer ports.
   Bound into rtb_timer; shadows control and irq enable from bus writes. */
`timescale 1ns/10ps
module rtb_timer_chk
(
  input wire logic mclk, // clk
  input wire logic srst, // rst
  input wire logic [rtb_pkg::RTB_ADDR_W-1:0] avs_address, // addr
  input wire logic avs_read, // rd
  input wire logic avs_write, // wr
  input wire logic [31:0] avs_writedata, // data
  input wire logic avs_waitrequest, // stall
  input wire logic [1:0] uart0_mode, // mode
  input wire logic [1:0] uart1_mode, // mode
  input wire logic uart1_framing_error, // fe
  input wire logic uart1_mode_bit0, // mb0
  input wire logic overflow_tick, // ovf
  input wire logic uart0_use_this_timer, // sel
  input wire logic uart1_double_rate, // dbl
  input wire logic uart1_control_bit7, // bit7
  input wire logic irq // irq
);
  import rtb_pkg::*;
  logic [7:0] c_q;
  logic [7:0] e_q;
  // only idle-state writes land, as in the slave
  wire wr = avs_write && avs_waitrequest;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      c_q <= 8'h00;
      e_q <= 8'h00;
    end
    else if (wr && avs_address[9:2] == RTB_IDX_CTRL)
      c_q <= avs_writedata[7:0];
    else if (wr && avs_address[9:2] == RTB_IDX_IRQ_EN)
      e_q <= avs_writedata[7:0];
  end
  property p_ans;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_one: assert property (p_one) else $error("long answer");
  // steering flops take the control value written at the same edge
  property p_u0;
    !$past(srst) |-> uart0_use_this_timer == (c_q[5] && $past(uart0_mode[0]));
  endproperty
  a_u0: assert property (p_u0) else $error("uart0 source");
  property p_u1;
    !$past(srst) |-> uart1_double_rate == (c_q[7] && $past(uart1_mode) == 2'h2);
  endproperty
  a_u1: assert property (p_u1) else $error("uart1 doubler");
  property p_fe;
    !$past(srst) |-> uart1_control_bit7 ==
      (c_q[6] ? $past(uart1_framing_error) : $past(uart1_mode_bit0));
  endproperty
  a_fe: assert property (p_fe) else $error("bit7 routing");
  property p_halt;
    !c_q[3] && !$past(c_q[3]) && !$past(c_q[3], 2) && !$past(c_q[3], 3) |-> !overflow_tick;
  endproperty
  a_halt: assert property (p_halt) else $error("halted count");
  property p_ovf;
    overflow_tick && e_q[0] |-> ##[1:2] irq;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow irq");
  property p_rst;
    $past(srst) |-> avs_waitrequest && !irq && !overflow_tick;
  endproperty
  a_rst: assert property (p_rst) else $error("reset outputs");
endmodule : rtb_timer_chk
bind rtb_timer rtb_timer_chk u_chk (.*);

// ===== verification/tb.sv
/* Self-checking bench for rtb_timer.
   Drives bus and uart inputs itself; one clock, no partner. */
`timescale 1ns/10ps
module tb;
  import rtb_pkg::*;
  logic mclk = 1'b0, srst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, isr_enter = 1'b0;
  logic [RTB_ADDR_W-1:0] avs_address = '0;
  logic [31:0] avs_writedata = '0, avs_readdata, r = 32'h4EF7229D;
  logic [3:0] avs_byteenable = 4'hF;
  logic [1:0] uart0_mode = 2'h0, uart1_mode = 2'h0;
  logic uart1_framing_error = 1'b0, uart1_mode_bit0 = 1'b0, avs_waitrequest;
  logic overflow_tick, uart0_use_this_timer, uart1_double_rate, uart1_control_bit7, irq;
  logic [7:0] q;
  logic [15:0] v;
  int n_mismatch = 0, n_checks = 0, c;
  rtb_timer DUT (.*);
  always #10 mclk = ~mclk;
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nx
  function automatic logic [15:0] period(input int p);
    return 16'(4 << p);
  endfunction : period
  always @(posedge mclk)
  begin
    r <= nx(r);
    {uart1_mode_bit0, uart1_framing_error, uart1_mode, uart0_mode} <= r[5:0];
  end
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    avs_address <= {a, 2'b00};
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= !w;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e)
    begin
      $display("[FAIL] %s exp %h got %h", s, e, g);
      n_mismatch++;
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string s);
    bus(1'b0, a, 8'h00);
    chk(s, e, q);
  endtask : rd
  // waits for the next overflow pulse, c holds the cycles spent
  task automatic per;
    c = 0;
    do
    begin
      @(posedge mclk);
      c++;
    end
    while (overflow_tick !== 1'b1 && c < 70000);
  endtask : per
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up
  initial
  begin
    #1700000;
    n_mismatch++;
    wrap_up();
  end
  initial
  begin
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    rd(RTB_IDX_CTRL, RTB_CTRL_RST, "ctrl");
    rd(RTB_IDX_RHI, RTB_RELOAD_RST, "rhi");
    rd(8'hFF, 8'h00, "unmapped");
    v = r[15:0];
    bus(1'b1, RTB_IDX_RLO, v[7:0]);
    bus(1'b1, RTB_IDX_RHI, v[15:8]);
    rd(RTB_IDX_RLO, v[7:0], "rlo");
    rd(RTB_IDX_RHI, v[15:8], "rhi");
    bus(1'b1, RTB_IDX_CTRL, 8'h10);
    rd(RTB_IDX_CTRL, 8'h10, "flag set");
    isr_enter <= 1'b1;
    @(posedge mclk);
    isr_enter <= 1'b0;
    rd(RTB_IDX_CTRL, 8'h00, "isr clear");
    repeat (3)
    begin
      v = r[15:0];
      bus(1'b1, RTB_IDX_CTRL, {v[7:5], 5'h00});
      repeat (8) @(posedge mclk);
      rd(RTB_IDX_CTRL, {v[7:5], 5'h00}, "uart bits");
    end
    $display("test registers done");
    bus(1'b1, RTB_IDX_IRQ_EN, 8'h01);
    bus(1'b1, RTB_IDX_RLO, 8'hFC);
    bus(1'b1, RTB_IDX_RHI, 8'hFF);
    for (int p = 0; p < 8; p++)
    begin
      v = 16'(p);
      bus(1'b1, RTB_IDX_CTRL, {5'h01, v[2:0]});
      per();
      per();
      chk("period", period(p), c[15:0]);
      rd(RTB_IDX_CTRL, {5'h03, v[2:0]}, "flag");
      bus(1'b1, RTB_IDX_CTRL, 8'h00);
    end
    rd(RTB_IDX_CNT_LO, 8'hFC, "reload wrap");
    repeat (20) @(posedge mclk);
    rd(RTB_IDX_CNT_LO, q, "hold");
    $display("test timer done");
    rd(RTB_IDX_IRQ_STAT, 8'h03, "status");
    chk("irq", 16'(1), 16'(irq));
    bus(1'b1, RTB_IDX_IRQ_EN, 8'h00);
    repeat (2) @(posedge mclk);
    chk("irq masked", 16'(0), 16'(irq));
    bus(1'b1, RTB_IDX_IRQ_EN, 8'h01);
    bus(1'b1, RTB_IDX_IRQ_CLR, 8'h03);
    repeat (2) @(posedge mclk);
    chk("irq cleared", 16'(0), 16'(irq));
    rd(RTB_IDX_IRQ_STAT, 8'h00, "status");
    $display("test irq done");
    wrap_up();
  end
endmodule : tb
